// ===== flash_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_map.svh"
module flash_host #(
  parameter int READY_CYC = `CYC_UP(`T_READY_NS),
  parameter int SETTLE_CYC = `BUSY_SETTLE_CYC
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CLK_EN,
  input wire logic REQ,
  input wire logic [3:0] REQ_OP,
  input wire logic [`ADDR_W-1:0] REQ_ADDR,
  input wire logic [`DATA_W-1:0] REQ_DATA,
  output logic BUSY,
  output logic DONE,
  output logic REFUSED,
  output logic [`DATA_W-1:0] RDATA,
  output logic ID_MODE,
  output logic ERASE_ACTIVE,
  output logic CHIP_SELECT_N,
  output logic OUTPUT_GATE_N,
  output logic WRITE_STROBE_N,
  output logic HW_RESET_N,
  output logic WIDTH_SELECT,
  output logic [`ADDR_W-1:0] ADDR,
  output logic [`DATA_W-1:0] DQ_O,
  output logic DQ_OE,
  input wire logic [`DATA_W-1:0] DQ_I,
  input wire logic READY_BUSY_N
);
  localparam int SETUP_CYC = `CYC_UP(`T_SETUP_NS);
  localparam int ACC_CYC = `CYC_UP(`T_ACC_NS);
  localparam int HOLD_CYC = `CYC_UP(`T_HOLD_NS);
  localparam int RP_CYC = `CYC_UP(`T_RP_NS);
  localparam int RH_CYC = `CYC_UP(`T_RH_NS);

  flash_cycle_if cyc ();

  flash_pkg::seq_state_t state_r;
  flash_pkg::op_t op_r;
  flash_pkg::op_t req_op;
  flash_pkg::step_t cur;
  logic [2:0] step_r;
  logic [`ADDR_W-1:0] addr_r;
  logic [`DATA_W-1:0] data_r;
  logic [15:0] cnt_r;
  logic req_r;
  logic suspended_r;
  logic is_read;
  logic is_multi;
  logic refuse;
  logic rp_end;
  logic rec_end;
  logic settle_end;
  logic rdy_end;
  logic [15:0] low_cnt_r;
  logic [15:0] since_r;

  function automatic flash_pkg::step_t step_word(
    input flash_pkg::op_t op, input logic [2:0] idx,
    input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
    flash_pkg::step_t s;
    s.last = 1'b0;
    s.addr = `UNLOCK1_ADDR;
    s.data = {8'h00, `UNLOCK1_DATA};
    if (idx == 3'd1 || idx == 3'd4) begin
      s.addr = `UNLOCK2_ADDR;
      s.data = {8'h00, `UNLOCK2_DATA};
    end
    case (op)
      flash_pkg::OP_PROGRAM: begin
        if (idx == 3'd2) s.data = {8'h00, `CMD_PROGRAM};
        if (idx == 3'd3) s = '{1'b1, a, d};
      end
      flash_pkg::OP_ERASE: begin
        if (idx == 3'd2) s.data = {8'h00, `CMD_ERASE_SETUP};
        if (idx == 3'd5) begin
          s.last = 1'b1;
          s.addr = {a[`SECTOR_HI:`SECTOR_LO], 12'h000};
          s.data = {8'h00, `CMD_SECTOR_ERASE};
        end
      end
      flash_pkg::OP_ID_ENTER: begin
        if (idx == 3'd2) begin
          s.last = 1'b1;
          s.data = {8'h00, `CMD_ID};
        end
      end
      flash_pkg::OP_SUSPEND: s = '{1'b1, a, {8'h00, `CMD_SUSPEND}};
      flash_pkg::OP_RESUME: s = '{1'b1, a, {8'h00, `CMD_RESUME}};
      flash_pkg::OP_RESET_CMD: s = '{1'b1, a, {8'h00, `CMD_RESET}};
      flash_pkg::OP_PROT_VERIFY:
        s = '{1'b1, {a[`SECTOR_HI:`SECTOR_LO], 10'h000, `PROT_LOW}, d};
      default: s = '{1'b1, a, d};
    endcase
    return s;
  endfunction

  assign req_op = flash_pkg::op_t'(REQ_OP);
  assign cur = step_word(op_r, step_r, addr_r, data_r);
  assign is_read = (op_r == flash_pkg::OP_READ) ||
                   (op_r == flash_pkg::OP_PROT_VERIFY);
  assign is_multi = (op_r == flash_pkg::OP_PROGRAM) ||
                    (op_r == flash_pkg::OP_ERASE) ||
                    (op_r == flash_pkg::OP_ID_ENTER);
  // Host-side guard: the flash would silently drop these
  assign refuse =
    (req_op == flash_pkg::OP_SUSPEND && (!ERASE_ACTIVE || suspended_r)) ||
    (req_op == flash_pkg::OP_RESUME && !suspended_r) ||
    (req_op == flash_pkg::OP_RESET_CMD && ERASE_ACTIVE && !suspended_r) ||
    (req_op == flash_pkg::OP_ERASE && ERASE_ACTIVE) ||
    (req_op == flash_pkg::OP_PROGRAM && ERASE_ACTIVE && !suspended_r) ||
    (ID_MODE && (req_op == flash_pkg::OP_PROGRAM ||
                 req_op == flash_pkg::OP_ERASE ||
                 req_op == flash_pkg::OP_ID_ENTER)) ||
    (REQ_OP > 4'h8);
  assign rp_end = (cnt_r >= 16'(RP_CYC - 1));
  // Wait both the read delay and ready, ready bounded by the READY_CYC timeout
  assign rec_end = (cnt_r >= 16'(RH_CYC - 1)) &&
                   (READY_BUSY_N || cnt_r >= 16'(READY_CYC - 1));
  assign settle_end = (cnt_r == 16'(SETTLE_CYC - 1));
  assign rdy_end = READY_BUSY_N || (cnt_r == 16'(READY_CYC - 1));

  assign cyc.req = req_r;
  assign cyc.wr = ~is_read;
  assign cyc.addr = cur.addr;
  assign cyc.wdata = cur.data;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_r <= flash_pkg::S_RSTLOW;
      op_r <= flash_pkg::OP_HW_RESET;
      step_r <= 3'd0;
      addr_r <= 19'h00000;
      data_r <= 16'h0000;
      cnt_r <= 16'h0000;
      req_r <= 1'b0;
      suspended_r <= 1'b0;
      BUSY <= 1'b1;
      DONE <= 1'b0;
      REFUSED <= 1'b0;
      RDATA <= 16'h0000;
      ID_MODE <= 1'b0;
      ERASE_ACTIVE <= 1'b0;
      HW_RESET_N <= 1'b0;
      WIDTH_SELECT <= `WORD_MODE;
    end else if (CLK_EN) begin
      DONE <= 1'b0;
      REFUSED <= 1'b0;
      req_r <= 1'b0;
      cnt_r <= cnt_r + 16'h0001;
      case (state_r)
        flash_pkg::S_IDLE: begin
          if (READY_BUSY_N && !suspended_r) begin
            ERASE_ACTIVE <= 1'b0;
          end
          if (REQ && refuse) begin
            REFUSED <= 1'b1;
          end else if (REQ && req_op == flash_pkg::OP_HW_RESET) begin
            HW_RESET_N <= 1'b0;
            cnt_r <= 16'h0000;
            BUSY <= 1'b1;
            op_r <= req_op;
            state_r <= flash_pkg::S_RSTLOW;
          end else if (REQ) begin
            op_r <= req_op;
            addr_r <= REQ_ADDR;
            data_r <= REQ_DATA;
            step_r <= 3'd0;
            req_r <= 1'b1;
            BUSY <= 1'b1;
            state_r <= flash_pkg::S_CMD;
          end
        end
        flash_pkg::S_CMD: begin
          cnt_r <= 16'h0000;
          if (cyc.done && !cur.last) begin
            step_r <= step_r + 3'd1;
            req_r <= 1'b1;
          end else if (cyc.done) begin
            if (is_read) RDATA <= cyc.rdata;
            if (op_r == flash_pkg::OP_ID_ENTER) ID_MODE <= 1'b1;
            if (op_r == flash_pkg::OP_RESET_CMD) ID_MODE <= 1'b0;
            if (op_r == flash_pkg::OP_SUSPEND) suspended_r <= 1'b1;
            if (op_r == flash_pkg::OP_RESUME) suspended_r <= 1'b0;
            if (op_r == flash_pkg::OP_ERASE) ERASE_ACTIVE <= 1'b1;
            if (op_r == flash_pkg::OP_PROGRAM ||
                op_r == flash_pkg::OP_ERASE) begin
              state_r <= flash_pkg::S_SETTLE;
            end else begin
              DONE <= 1'b1;
              BUSY <= 1'b0;
              state_r <= flash_pkg::S_IDLE;
            end
          end
        end
        flash_pkg::S_SETTLE: begin
          // Ready pin lags the last write; do not trust it at once
          if (settle_end) begin
            cnt_r <= 16'h0000;
            if (op_r == flash_pkg::OP_ERASE) begin
              DONE <= 1'b1;
              BUSY <= 1'b0;
              state_r <= flash_pkg::S_IDLE;
            end else begin
              state_r <= flash_pkg::S_WAITRDY;
            end
          end
        end
        flash_pkg::S_WAITRDY: begin
          if (rdy_end) begin
            DONE <= 1'b1;
            BUSY <= 1'b0;
            state_r <= flash_pkg::S_IDLE;
          end
        end
        flash_pkg::S_RSTLOW: begin
          if (rp_end) begin
            HW_RESET_N <= 1'b1;
            cnt_r <= 16'h0000;
            state_r <= flash_pkg::S_RSTREC;
          end
        end
        flash_pkg::S_RSTREC: begin
          if (rec_end) begin
            ID_MODE <= 1'b0;
            ERASE_ACTIVE <= 1'b0;
            suspended_r <= 1'b0;
            DONE <= 1'b1;
            BUSY <= 1'b0;
            state_r <= flash_pkg::S_IDLE;
          end
        end
        default: state_r <= flash_pkg::S_IDLE;
      endcase
    end
  end

  flash_cycle #(
    .SETUP_CYC(SETUP_CYC),
    .STROBE_CYC(ACC_CYC),
    .HOLD_CYC(HOLD_CYC)
  ) u_cycle (
    .clk(MCLK),
    .rst(RST),
    .clk_en(CLK_EN),
    .cyc(cyc.eng),
    .ce_n(CHIP_SELECT_N),
    .oe_n(OUTPUT_GATE_N),
    .we_n(WRITE_STROBE_N),
    .addr(ADDR),
    .dq_o(DQ_O),
    .dq_oe(DQ_OE),
    .dq_i(DQ_I)
  );

  // Helper counters for the reset timing checks
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      low_cnt_r <= 16'h0000;
      since_r <= 16'h0000;
    end else begin
      low_cnt_r <= HW_RESET_N ? 16'h0000 :
                   (low_cnt_r == 16'hffff) ? low_cnt_r : low_cnt_r + 16'h0001;
      since_r <= !HW_RESET_N ? 16'h0000 :
                 (since_r == 16'hffff) ? since_r : since_r + 16'h0001;
    end
  end

  chk_reset_pulse_len: assert property (@(posedge MCLK) disable iff (RST)
    $rose(HW_RESET_N) |-> (low_cnt_r >= 16'(RP_CYC)))
    else $error("reset pulse shorter than minimum");

  chk_no_cycle_reset: assert property (@(posedge MCLK) disable iff (RST)
    !HW_RESET_N |-> CHIP_SELECT_N)
    else $error("bus cycle while flash held in reset");

  chk_read_after_reset: assert property (@(posedge MCLK) disable iff (RST)
    $fell(CHIP_SELECT_N) |-> (since_r >= 16'(RH_CYC)))
    else $error("access too soon after reset release");

  chk_unlock_first: assert property (@(posedge MCLK) disable iff (RST)
    (req_r && is_multi && step_r == 3'd0) |->
      (cyc.addr == `UNLOCK1_ADDR && cyc.wdata[7:0] == `UNLOCK1_DATA))
    else $error("command sequence without unlock pattern");

  chk_suspend_gate: assert property (@(posedge MCLK) disable iff (RST)
    (req_r && (op_r == flash_pkg::OP_SUSPEND ||
               op_r == flash_pkg::OP_RESUME)) |-> ERASE_ACTIVE)
    else $error("suspend or resume sent with no erase running");

  chk_reset_ends_id: assert property (@(posedge MCLK) disable iff (RST)
    (CLK_EN && state_r == flash_pkg::S_CMD && cyc.done && cur.last &&
     op_r == flash_pkg::OP_RESET_CMD) |=> (!ID_MODE && DONE))
    else $error("reset code did not leave identifier mode");

  chk_protect_addr: assert property (@(posedge MCLK) disable iff (RST)
    (req_r && op_r == flash_pkg::OP_PROT_VERIFY) |->
      (cyc.addr[1:0] == `PROT_LOW && !cyc.wr &&
       cyc.addr[`SECTOR_HI:`SECTOR_LO] == addr_r[`SECTOR_HI:`SECTOR_LO]))
    else $error("protection verify address malformed");

  chk_no_reset_erase: assert property (@(posedge MCLK) disable iff (RST)
    (req_r && op_r == flash_pkg::OP_RESET_CMD) |-> (!ERASE_ACTIVE ||
      suspended_r))
    else $error("reset code sent while erase runs");
endmodule // flash_host
`default_nettype wire

// ===== flash_map.svh
`ifndef FLASH_MAP_SVH
`define FLASH_MAP_SVH

`define ADDR_W 19
`define DATA_W 16
`define SECTOR_HI 18
`define SECTOR_LO 12

`define UNLOCK1_ADDR 19'h00555
`define UNLOCK2_ADDR 19'h002aa
`define UNLOCK1_DATA 8'haa
`define UNLOCK2_DATA 8'h55
`define CMD_PROGRAM 8'ha0
`define CMD_ERASE_SETUP 8'h80
`define CMD_SECTOR_ERASE 8'h30
`define CMD_SUSPEND 8'hb0
`define CMD_RESUME 8'h30
`define CMD_RESET 8'hf0
`define CMD_ID 8'h90
`define PROT_LOW 2'b10
`define WORD_MODE 1'b1

`define CLK_MHZ 250
`define CYC_UP(ns) ((((ns) * `CLK_MHZ) + 999) / 1000)
`define T_SETUP_NS 10
`define T_ACC_NS 70
`define T_HOLD_NS 10
`define T_RP_NS 500
`define T_RH_NS 50
`define T_READY_NS 20000
`define BUSY_SETTLE_CYC 8

`endif

// ===== flash_pkg.sv
package flash_pkg;

  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_PROGRAM = 4'h1,
    OP_ERASE = 4'h2,
    OP_SUSPEND = 4'h3,
    OP_RESUME = 4'h4,
    OP_RESET_CMD = 4'h5,
    OP_ID_ENTER = 4'h6,
    OP_PROT_VERIFY = 4'h7,
    OP_HW_RESET = 4'h8
  } op_t;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_CMD = 6'h02,
    S_SETTLE = 6'h04,
    S_WAITRDY = 6'h08,
    S_RSTLOW = 6'h10,
    S_RSTREC = 6'h20
  } seq_state_t;

  typedef enum logic [3:0] {
    C_IDLE = 4'h1,
    C_SETUP = 4'h2,
    C_STROBE = 4'h4,
    C_HOLD = 4'h8
  } cyc_state_t;

  typedef struct packed {
    logic last;
    logic [18:0] addr;
    logic [15:0] data;
  } step_t;

endpackage

// ===== flash_cycle_if.sv
`timescale 1ns/1ps
`default_nettype none
interface flash_cycle_if;
  logic req;
  logic wr;
  logic [18:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport seq (output req, output wr, output addr, output wdata,
    input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata,
    output done, output rdata);
endinterface // flash_cycle_if
`default_nettype wire

// ===== flash_cycle.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_map.svh"
module flash_cycle #(
  parameter int SETUP_CYC = 3,
  parameter int STROBE_CYC = 18,
  parameter int HOLD_CYC = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  flash_cycle_if.eng cyc,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [`ADDR_W-1:0] addr,
  output logic [`DATA_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [`DATA_W-1:0] dq_i
);
  flash_pkg::cyc_state_t state_r;
  logic [7:0] cnt_r;
  logic [7:0] lim;
  logic cnt_end;
  logic wr_r;
  logic done_r;
  logic [`DATA_W-1:0] rdata_r;

  assign lim = (state_r == flash_pkg::C_SETUP) ? 8'(SETUP_CYC) :
               (state_r == flash_pkg::C_STROBE) ? 8'(STROBE_CYC) :
               8'(HOLD_CYC);
  assign cnt_end = (cnt_r == lim - 8'h01);
  assign cyc.done = done_r;
  assign cyc.rdata = rdata_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= flash_pkg::C_IDLE;
      cnt_r <= 8'h00;
      wr_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= 16'h0000;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      addr <= 19'h00000;
      dq_o <= 16'h0000;
      dq_oe <= 1'b0;
    end else if (clk_en) begin
      done_r <= 1'b0;
      cnt_r <= (state_r == flash_pkg::C_IDLE || cnt_end) ? 8'h00 :
               cnt_r + 8'h01;
      case (state_r)
        flash_pkg::C_IDLE: begin
          if (cyc.req) begin
            addr <= cyc.addr;
            dq_o <= cyc.wdata;
            dq_oe <= cyc.wr;
            wr_r <= cyc.wr;
            ce_n <= 1'b0;
            state_r <= flash_pkg::C_SETUP;
          end
        end
        flash_pkg::C_SETUP: begin
          // Address and select settle before any strobe falls
          if (cnt_end) begin
            oe_n <= wr_r;
            we_n <= ~wr_r;
            state_r <= flash_pkg::C_STROBE;
          end
        end
        flash_pkg::C_STROBE: begin
          if (cnt_end) begin
            oe_n <= 1'b1;
            we_n <= 1'b1;
            if (!wr_r) begin
              rdata_r <= dq_i;
            end
            state_r <= flash_pkg::C_HOLD;
          end
        end
        flash_pkg::C_HOLD: begin
          if (cnt_end) begin
            ce_n <= 1'b1;
            dq_oe <= 1'b0;
            done_r <= 1'b1;
            state_r <= flash_pkg::C_IDLE;
          end
        end
        default: state_r <= flash_pkg::C_IDLE;
      endcase
    end
  end

  chk_read_strobes: assert property (@(posedge clk) disable iff (rst)
    !oe_n |-> (!ce_n && we_n && !dq_oe))
    else $error("read strobe without select or with write strobe");

  chk_write_strobes: assert property (@(posedge clk) disable iff (rst)
    !we_n |-> (!ce_n && oe_n && dq_oe))
    else $error("write strobe without select or with output gate");

  chk_cycle_length: assert property (@(posedge clk) disable iff (rst)
    ($fell(ce_n) && clk_en) |-> ##1 (!ce_n)[*2])
    else $error("bus cycle shorter than setup");
endmodule // flash_cycle
`default_nettype wire

// ===== flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter logic [15:0] MAKER_CODE = 16'h003c, // Arbitrary value
  parameter logic [15:0] PART_CODE = 16'h1a7e, // Arbitrary value
  parameter logic [6:0] PROT_SECTOR = 7'h05,
  parameter int PROG_CYC = 10,
  parameter int ERASE_CYC = 600,
  parameter int RECOV_CYC = 30
) (
  input wire logic clk,
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic write_strobe_n,
  input wire logic hw_reset_n,
  input wire logic width_select,
  input wire logic [18:0] addr,
  input wire logic [15:0] dq_o,
  output logic [15:0] dq_i,
  output logic ready_busy_n
);
  logic [15:0] mem [int];
  int step = 0;
  int cnt = 0;
  logic we_q = 1'b1;
  logic id_mode = 1'b0;
  logic erasing = 1'b0;
  logic sus = 1'b0;
  logic [6:0] esec = 7'h00;
  logic [15:0] rd;
  initial dq_i = 16'h0000;
  assign ready_busy_n = (cnt == 0) || sus;
  always_comb begin
    if (id_mode && addr[1:0] == 2'b00) rd = MAKER_CODE;
    else if (id_mode && addr[1:0] == 2'b01) rd = PART_CODE;
    else if (id_mode) rd = {15'h0000, addr[18:12] == PROT_SECTOR};
    else if (mem.exists(int'(addr))) rd = mem[int'(addr)];
    else rd = 16'hffff;
  end
  task automatic cmd(input logic [18:0] a, input logic [15:0] d);
    logic [10:0] lo;
    lo = a[10:0];
    if (cnt > 0 && !erasing) return;
    if (erasing && !sus) begin
      if (d[7:0] == 8'hb0) sus <= 1'b1;
      return;
    end
    if (d[7:0] == 8'hf0 && step != 3) begin
      step <= 0;
      id_mode <= 1'b0;
      return;
    end
    if (sus && step == 0 && d[7:0] == 8'h30) begin
      sus <= 1'b0;
      return;
    end
    step <= 0;
    case (step)
      0: if (lo == 11'h555 && d[7:0] == 8'haa) step <= 1;
      1: if (lo == 11'h2aa && d[7:0] == 8'h55) step <= 2;
      2: if (lo == 11'h555) begin
        if (d[7:0] == 8'h90) id_mode <= 1'b1;
        if (d[7:0] == 8'ha0) step <= 3;
        if (d[7:0] == 8'h80) step <= 4;
      end
      3: begin
        if (a[18:12] != PROT_SECTOR) mem[int'(a)] = d;
        cnt <= PROG_CYC;
      end
      4: if (lo == 11'h555 && d[7:0] == 8'haa) step <= 5;
      5: if (lo == 11'h2aa && d[7:0] == 8'h55) step <= 6;
      6: if (d[7:0] == 8'h30) begin
        erasing <= 1'b1;
        esec <= a[18:12];
        cnt <= ERASE_CYC;
      end
      default: step <= 0;
    endcase
  endtask
  always @(posedge clk) begin
    we_q <= write_strobe_n;
    if (!output_gate_n && !chip_select_n && hw_reset_n) dq_i <= rd;
    else dq_i <= ~dq_i;
    if (!hw_reset_n) begin
      step <= 0;
      id_mode <= 1'b0;
      erasing <= 1'b0;
      sus <= 1'b0;
      if (cnt > 0) cnt <= RECOV_CYC;
    end else begin
      if (cnt > 0 && !sus) cnt <= cnt - 1;
      if (cnt == 1 && erasing && !sus) begin
        foreach (mem[k]) if (k[18:12] == esec) mem[k] = 16'hffff;
        erasing <= 1'b0;
      end
      if (!we_q && write_strobe_n && !chip_select_n) cmd(addr, dq_o);
    end
  end
endmodule // flash_dev_model
`default_nettype wire

// ===== flash_host_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_map.svh"
module flash_host_tb_top;
  localparam logic [15:0] MAKER = 16'h003c; // Arbitrary value
  localparam logic [15:0] PART = 16'h1a7e; // Arbitrary value
  localparam logic [6:0] PSEC = 7'h05;
  logic mclk = 1'b0, rst = 1'b1, clk_en = 1'b1, req = 1'b0;
  logic [3:0] req_op = 4'h0;
  logic [18:0] req_addr = 19'h00000, addr;
  logic [15:0] req_data = 16'h0000, rdata, dq_o, dq_i;
  logic busy, done, refused, id_mode, erase_active, cs_n, oe_n, we_n;
  logic hw_rst_n, width_sel, dq_oe, ready_busy_n;
  int n_errors = 0, n_compared = 0, low_cnt = 0, since_rise = 0, i;
  logic hw_q = 1'b0, oe_q = 1'b1, e_id = 1'b0, e_ea = 1'b0, e_sus = 1'b0;
  logic [6:0] e_sec;
  logic [15:0] emem [int];
  logic [18:0] aq [$];
  logic [18:0] a;
  always #2 mclk = ~mclk;
  flash_host #(.READY_CYC(200), .SETTLE_CYC(2)) dut (.MCLK(mclk), .RST(rst),
    .CLK_EN(clk_en), .REQ(req), .REQ_OP(req_op), .REQ_ADDR(req_addr),
    .REQ_DATA(req_data), .BUSY(busy), .DONE(done), .REFUSED(refused),
    .RDATA(rdata), .ID_MODE(id_mode), .ERASE_ACTIVE(erase_active),
    .CHIP_SELECT_N(cs_n), .OUTPUT_GATE_N(oe_n), .WRITE_STROBE_N(we_n),
    .HW_RESET_N(hw_rst_n), .WIDTH_SELECT(width_sel), .ADDR(addr),
    .DQ_O(dq_o), .DQ_OE(dq_oe), .DQ_I(dq_i), .READY_BUSY_N(ready_busy_n));
  flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART),
    .PROT_SECTOR(PSEC)) flash (.clk(mclk), .chip_select_n(cs_n),
    .output_gate_n(oe_n), .write_strobe_n(we_n), .hw_reset_n(hw_rst_n),
    .width_select(width_sel), .addr(addr), .dq_o(dq_o), .dq_i(dq_i),
    .ready_busy_n(ready_busy_n));
  task automatic complete_run;
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check_data(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_data({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic give_up;
    n_errors++;
    complete_run();
  endtask
  function automatic logic exp_ref(input logic [3:0] op);
    case (op)
      4'h1: return (e_ea && !e_sus) || e_id;
      4'h2: return e_ea || e_id;
      4'h3: return !(e_ea && !e_sus);
      4'h4: return !e_sus;
      4'h5: return e_ea && !e_sus;
      4'h6: return e_id;
      4'h0, 4'h7, 4'h8: return 1'b0;
      default: return 1'b1;
    endcase
  endfunction
  task automatic run_op(input logic [3:0] op, input logic [18:0] ad,
      input logic [15:0] d);
    int k;
    logic r;
    r = exp_ref(op);
    // Back on a falling edge, else a request after DONE falls between edges
    @(negedge mclk);
    for (k = 0; busy !== 1'b0; k++) begin
      if (k > 30000) give_up();
      @(negedge mclk);
    end
    req = 1'b1;
    req_op = op;
    req_addr = ad;
    req_data = d;
    @(negedge mclk);
    req = 1'b0;
    for (k = 0; done !== 1'b1 && refused !== 1'b1; k++) begin
      if (k > 30000) give_up();
      @(posedge mclk);
      #1;
    end
    check_bit(refused, r);
    if (!r) begin
      case (op)
        4'h0: if (e_id) check_data({8'h00, rdata[7:0]}, {8'h00, ad[0] ? PART[7:0] : MAKER[7:0]});
          else check_data(rdata, emem.exists(int'(ad)) ? emem[int'(ad)] : 16'hffff);
        4'h1: emem[int'(ad)] = d;
        4'h2: {e_ea, e_sec} = {1'b1, ad[18:12]};
        4'h3: e_sus = 1'b1;
        4'h4: e_sus = 1'b0;
        4'h5: e_id = 1'b0;
        4'h6: e_id = 1'b1;
        4'h7: check_data({8'h00, rdata[7:0]}, {15'h0000, ad[18:12] == PSEC});
        4'h8: {e_id, e_ea, e_sus} = 3'b000;
        default: ;
      endcase
    end
  endtask
  // No reset guard: the reset pin is already low during power-up reset
  always @(negedge mclk) begin
    hw_q <= hw_rst_n;
    oe_q <= oe_n;
    low_cnt <= hw_rst_n ? 0 : low_cnt + 1;
    since_rise <= since_rise + 1;
    if (hw_rst_n && !hw_q) since_rise <= 0;
    if (hw_rst_n && !hw_q) check_bit(low_cnt >= `CYC_UP(`T_RP_NS), 1'b1);
    if (!oe_n && oe_q) check_bit(since_rise >= `CYC_UP(`T_RH_NS), 1'b1);
    if (!hw_rst_n) check_data({13'h0, cs_n, oe_n, we_n}, 16'h0007);
    if (!oe_n) check_data({13'h0, cs_n, we_n, dq_oe}, 16'h0002);
    if (!we_n) check_data({13'h0, cs_n, oe_n, dq_oe}, 16'h0003);
  end
  initial begin
    i = $urandom(32'h2d2e);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    run_op(4'h0, 19'h01234, 16'h0000);
    check_bit(width_sel, `WORD_MODE);
    aq = '{19'h01010, 19'h02020};
    for (i = 0; i < 6; i++) aq.push_back(19'($urandom) & 19'h00fff);
    foreach (aq[k]) run_op(4'h1, aq[k], 16'($urandom));
    fork
      begin
        repeat (8) @(negedge mclk);
        clk_en = 1'b0;
        repeat (10) @(negedge mclk);
        clk_en = 1'b1;
      end
    join_none
    foreach (aq[k]) run_op(4'h0, aq[k], 16'h0000);
    run_op(4'h6, 19'h00000, 16'h0000);
    check_bit(id_mode, 1'b1);
    for (i = 0; i < 2; i++) run_op(4'h0, 19'(i), 16'h0000);
    run_op(4'h1, 19'h00100, 16'h1111);
    run_op(4'h5, 19'h00000, 16'h0000);
    check_bit(id_mode, 1'b0);
    run_op(4'h0, aq[2], 16'h0000);
    for (i = 0; i < 2; i++) begin
      run_op(4'h6, 19'h00000, 16'h0000);
      run_op(4'h7, {i ? PSEC : 7'h02, 12'h000}, 16'h0000);
      run_op(4'h5, 19'h00000, 16'h0000);
    end
    for (i = 3; i < 16; i++) if (i < 5 || i > 8) run_op(4'(i), 19'h0, 16'h0);
    run_op(4'h2, 19'h01000, 16'h0000);
    run_op(4'h5, 19'h00000, 16'h0000);
    for (i = 1; i < 4; i++) run_op(4'(i * (i - 1) / 2 + (i == 1)), 19'h0, 16'h0);
    run_op(4'h3, 19'h00000, 16'h0000);
    run_op(4'h0, 19'h02020, 16'h0000);
    run_op(4'h4, 19'h00000, 16'h0000);
    run_op(4'h4, 19'h00000, 16'h0000);
    for (i = 0; ready_busy_n !== 1'b1 || erase_active !== 1'b0; i++) begin
      if (i > 2000) give_up();
      @(negedge mclk);
    end
    e_ea = 1'b0;
    foreach (emem[k]) if (k[18:12] == e_sec) emem[k] = 16'hffff;
    run_op(4'h0, 19'h01010, 16'h0000);
    run_op(4'h0, 19'h02020, 16'h0000);
    run_op(4'h2, 19'h03000, 16'h0000);
    run_op(4'h8, 19'h00000, 16'h0000);
    check_bit(erase_active, 1'b0);
    run_op(4'h1, 19'h03030, 16'h5aa5);
    run_op(4'h0, 19'h03030, 16'h0000);
    complete_run();
  end
endmodule // flash_host_tb_top
`default_nettype wire
